// ==== rtl/mic_pkg.sv ====
// package of the interrupt controller: register map, source order, vectors
// assumes an 8-bit register port with one-cycle read latency
`default_nettype none
package mic_pkg;
	localparam logic [7:0] OFS_ENABLE_MAIN   = 8'hA8;
	localparam logic [7:0] OFS_PRIORITY_MAIN = 8'hB8;
	localparam logic [7:0] OFS_ENABLE_EXT    = 8'hE8;
	localparam logic [7:0] OFS_PRIORITY_EXT  = 8'hF8;
	localparam logic [7:0] OFS_FLAG_EXT      = 8'h91;
	localparam logic [7:0] OFS_DEBUG_ID      = 8'hEF;
	localparam logic [7:0] RST_ENABLE_MAIN   = 8'h00;
	localparam logic [7:0] RST_PRIORITY_MAIN = 8'h00;
	localparam logic [7:0] RST_ENABLE_EXT    = 8'h00;
	localparam logic [7:0] RST_PRIORITY_EXT  = 8'h00;
	localparam logic [7:0] RST_DEBUG_ID      = 8'h00;
	localparam int         GLOBAL_EN_BIT     = 7;
	localparam int         I2CM_FLAG_BIT     = 0;
	localparam logic [7:0] PRIO_MAIN_MASK    = 8'h7F;
	localparam int         NUM_SRC           = 15;
	localparam int         NUM_CORE_SRC      = 7;
	localparam int         NUM_EXT_SRC       = 6;
	localparam int         NUM_PIN_SRC       = 2;
	// natural order index of each source, 0 is highest
	localparam int         SRC_TIMER0        = 1;
	localparam int         SRC_TIMER1        = 3;
	localparam int         SRC_I2CM          = 7;
	localparam logic [7:0] VEC_BASE          = 8'h03;
	localparam logic [7:0] VEC_STEP          = 8'h08;
	localparam logic [7:0] VEC_BREAKPOINT    = 8'h7B;
	localparam logic [7:0] VEC_DEBUG         = 8'h83;
	localparam logic [4:0] ID_BREAKPOINT     = 5'h0F;
	localparam logic [4:0] ID_DEBUG          = 5'h10;
	localparam logic [4:0] ID_NONE           = 5'h1F;
endpackage
`default_nettype wire

// ==== rtl/mic_arb_if.sv ====
// carrier between the controller top and its arbiter
// assumes both ends run on core_clk
`timescale 1ns/10ps
`default_nettype none
interface mic_arb_if;
	logic [14:0] pend;
	logic [14:0] level;
	logic        dbgReq;
	logic        bkpReq;
	logic        valid;
	logic [4:0]  winId;
	logic        winHigh;
	modport ctrl (output pend, level, dbgReq, bkpReq,
	              input  valid, winId, winHigh);
	modport arb  (input  pend, level, dbgReq, bkpReq,
	              output valid, winId, winHigh);
endinterface
`default_nettype wire

// ==== rtl/mic_arbiter.sv ====
// combinational winner select for the interrupt controller
// assumes pend already gated by enables and in-service state
`timescale 1ns/10ps
`default_nettype none
module mic_arbiter (
	mic_arb_if.arb arb
);
	// lowest index set wins; helper used for both levels
	function automatic logic [4:0] firstSet(input logic [14:0] v);
		logic [4:0] r;
		r = mic_pkg::ID_NONE;
		for (int i = mic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	logic [14:0] hiPend;
	logic [14:0] loPend;
	always_comb begin
		hiPend = arb.pend & arb.level;
		loPend = arb.pend & ~arb.level;
		arb.valid   = 1'b1;
		arb.winHigh = 1'b1;
		if (arb.dbgReq) begin
			arb.winId = mic_pkg::ID_DEBUG;
		end else if (arb.bkpReq) begin
			arb.winId = mic_pkg::ID_BREAKPOINT;
		end else if (|hiPend) begin
			arb.winId = firstSet(hiPend);
		end else if (|loPend) begin
			arb.winId   = firstSet(loPend);
			arb.winHigh = 1'b0;
		end else begin
			arb.winId   = mic_pkg::ID_NONE;
			arb.valid   = 1'b0;
			arb.winHigh = 1'b0;
		end
	end
endmodule
`default_nettype wire

// ==== rtl/mic_ctrl.sv ====
// two-level prioritised interrupt controller top
// assumes sources are synchronous to core_clk; cpu acks one cycle pulses
//
// Functional notes
// - fifteen ordinary sources, each software-assigned low or high level
// - seven core, six on-chip peripheral, two pin-group sources
// - request lines sampled on rising system clock edge
// - cpu vectors to single highest priority enabled pending request
// - high level always beats low level
// - same level decided by fixed natural order, pin group 0 first
// - vectors 0x03 stepping by 8 to 0x73, breakpoint 0x7B, debug 0x83
// - timer 0 and 1 flags cleared by hardware, others by software
// - software write can clear a flag, never set one
// - debug above breakpoint above all ordinary sources
// - debug raised when debug port request id matches programmed id
// - breakpoint raised when breakpoint unit signals a match
// - debug and breakpoint taken even with global enable clear
// - global enable clear blocks ordinary sources, else per-source enables
// - main enable register layout, resets to zero
// - extended enable register layout, resets to zero
// - priority bit one means high level, zero low
// - main priority register layout, bit 7 unused, resets to zero
// - extended priority register same order as extended enable
// - group flags are OR of peripheral flags and ignore writes
// - i2c master flag at bit 0 of extended flags, software clears
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module mic_ctrl (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [7:0]  regRdata,
	input  wire logic [14:0] srcLevel,
	input  wire logic        i2cMasterSet,
	input  wire logic        debugPortMode,
	input  wire logic        debugReqStb,
	input  wire logic [7:0]  debugReqId,
	input  wire logic        breakpointMatch,
	input  wire logic        irqAck,
	input  wire logic        irqReturn,
	output logic             irqReq,
	output logic      [7:0]  irqVector,
	output logic             timer0Clear,
	output logic             timer1Clear,
	output logic      [1:0]  inServiceLevel
);
	////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0]  enMainReg;
	logic [7:0]  prMainReg;
	logic [7:0]  enExtReg;
	logic [7:0]  prExtReg;
	logic [7:0]  debugIdReg;
	logic        i2cmFlagReg;
	logic [14:0] srcSampleReg;
	logic        dbgFlagReg;
	logic        bkpFlagReg;
	logic        wrEnMain;
	logic        wrEnExt;
	logic        wrFlagExt;

	assign wrEnMain  = regWr && regAddr == mic_pkg::OFS_ENABLE_MAIN;
	assign wrEnExt   = regWr && regAddr == mic_pkg::OFS_ENABLE_EXT;
	assign wrFlagExt = regWr && regAddr == mic_pkg::OFS_FLAG_EXT;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			enMainReg <= mic_pkg::RST_ENABLE_MAIN;
			enExtReg  <= mic_pkg::RST_ENABLE_EXT;
		end else begin
			if (wrEnMain) begin
				enMainReg <= regWdata;
			end
			if (wrEnExt) begin
				enExtReg <= regWdata;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prMainReg  <= mic_pkg::RST_PRIORITY_MAIN;
			prExtReg   <= mic_pkg::RST_PRIORITY_EXT;
			debugIdReg <= mic_pkg::RST_DEBUG_ID;
		end else if (regWr) begin
			if (regAddr == mic_pkg::OFS_PRIORITY_MAIN) begin
				prMainReg <= regWdata & mic_pkg::PRIO_MAIN_MASK;
			end
			if (regAddr == mic_pkg::OFS_PRIORITY_EXT) begin
				prExtReg <= regWdata;
			end
			if (regAddr == mic_pkg::OFS_DEBUG_ID) begin
				debugIdReg <= regWdata;
			end
		end
	end

	// a new set beats a clear arriving in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			i2cmFlagReg <= 1'b0;
		end else if (i2cMasterSet) begin
			i2cmFlagReg <= 1'b1;
		end else if (wrFlagExt && !regWdata[mic_pkg::I2CM_FLAG_BIT]) begin
			i2cmFlagReg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// request sampling; peripherals own their flags, group lines are ORs
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			srcSampleReg <= 15'h0000;
		end else begin
			srcSampleReg <= srcLevel;
		end
	end

	logic [14:0] srcPending;
	always_comb begin
		srcPending = srcSampleReg;
		srcPending[mic_pkg::SRC_I2CM] = i2cmFlagReg;
	end

	// sticky debug and breakpoint flags, cleared when their vector is taken
	logic dbgHit;
	logic takeNow;
	logic [4:0] takeId;
	assign dbgHit = debugPortMode && debugReqStb && debugReqId == debugIdReg;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			dbgFlagReg <= 1'b0;
			bkpFlagReg <= 1'b0;
		end else begin
			if (dbgHit) begin
				dbgFlagReg <= 1'b1;
			end else if (takeNow && takeId == mic_pkg::ID_DEBUG) begin
				dbgFlagReg <= 1'b0;
			end
			if (breakpointMatch) begin
				bkpFlagReg <= 1'b1;
			end else if (takeNow && takeId == mic_pkg::ID_BREAKPOINT) begin
				bkpFlagReg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enables, in-service gating and arbitration
	logic [14:0] srcEnable;
	logic [14:0] srcLevelHigh;
	logic        hiActReg;
	logic        loActReg;
	logic        dbgActReg;

	assign srcEnable = {enExtReg, enMainReg[6:0]}
		& {15{enMainReg[mic_pkg::GLOBAL_EN_BIT]}};
	assign srcLevelHigh = {prExtReg, prMainReg[6:0]};

	mic_arb_if arbBus ();
	always_comb begin
		arbBus.pend   = 15'h0000;
		arbBus.dbgReq = dbgFlagReg && !dbgActReg;
		arbBus.bkpReq = bkpFlagReg && !dbgActReg;
		arbBus.level  = srcLevelHigh;
		if (!dbgActReg && !hiActReg) begin
			// low service in progress admits only high requests
			arbBus.pend = srcPending & srcEnable
				& (loActReg ? srcLevelHigh : 15'h7FFF);
		end
	end

	mic_arbiter uArb (
		.arb (arbBus.arb)
	);

	function automatic logic [7:0] vectorOf(input logic [4:0] id);
		logic [7:0] v;
		v = mic_pkg::VEC_BASE + 8'(id) * mic_pkg::VEC_STEP;
		if (id == mic_pkg::ID_BREAKPOINT) begin
			v = mic_pkg::VEC_BREAKPOINT;
		end
		if (id == mic_pkg::ID_DEBUG) begin
			v = mic_pkg::VEC_DEBUG;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// cpu handshake: request and vector follow the arbiter each cycle until ack, one vector per ack
	assign takeNow = irqReq && irqAck;
	logic [4:0] curIdReg;
	logic       curHighReg;
	assign takeId = curIdReg;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irqReq     <= 1'b0;
			irqVector  <= 8'h00;
			curIdReg   <= mic_pkg::ID_NONE;
			curHighReg <= 1'b0;
		end else if (takeNow) begin
			irqReq <= 1'b0;
		end else begin
			irqReq     <= arbBus.valid;
			irqVector  <= vectorOf(arbBus.winId);
			curIdReg   <= arbBus.winId;
			curHighReg <= arbBus.winHigh;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			timer0Clear <= 1'b0;
			timer1Clear <= 1'b0;
		end else begin
			timer0Clear <= takeNow && curIdReg == 5'(mic_pkg::SRC_TIMER0);
			timer1Clear <= takeNow && curIdReg == 5'(mic_pkg::SRC_TIMER1);
		end
	end

	// nesting: each return pops the innermost active level
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			loActReg  <= 1'b0;
			hiActReg  <= 1'b0;
			dbgActReg <= 1'b0;
		end else if (takeNow) begin
			if (curIdReg >= mic_pkg::ID_BREAKPOINT) begin
				dbgActReg <= 1'b1;
			end else if (curHighReg) begin
				hiActReg <= 1'b1;
			end else begin
				loActReg <= 1'b1;
			end
		end else if (irqReturn) begin
			if (dbgActReg) begin
				dbgActReg <= 1'b0;
			end else if (hiActReg) begin
				hiActReg <= 1'b0;
			end else begin
				loActReg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			inServiceLevel <= 2'h0;
		end else begin
			inServiceLevel <= dbgActReg ? 2'h3 : hiActReg ? 2'h2
				: loActReg ? 2'h1 : 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port; unmapped addresses read zero
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			unique case (regAddr)
				mic_pkg::OFS_ENABLE_MAIN:   regRdata <= enMainReg;
				mic_pkg::OFS_PRIORITY_MAIN: regRdata <= prMainReg;
				mic_pkg::OFS_ENABLE_EXT:    regRdata <= enExtReg;
				mic_pkg::OFS_PRIORITY_EXT:  regRdata <= prExtReg;
				mic_pkg::OFS_DEBUG_ID:      regRdata <= debugIdReg;
				mic_pkg::OFS_FLAG_EXT: begin
					// group bits mirror the sampled lines
					regRdata <= {srcSampleReg[14:12], 1'b0,
						srcSampleReg[10:8], i2cmFlagReg};
				end
				default: regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_HIGH_BEATS_LOW: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(arbBus.valid && |(arbBus.pend & arbBus.level) && !arbBus.dbgReq
		&& !arbBus.bkpReq) |-> arbBus.winHigh)
		else $error("low level won over pending high");
	AST_DEBUG_FIRST: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		arbBus.dbgReq |-> arbBus.winId == mic_pkg::ID_DEBUG)
		else $error("debug not ranked first");
	AST_GLOBAL_BLOCK: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!enMainReg[mic_pkg::GLOBAL_EN_BIT] |-> arbBus.pend == 15'h0000)
		else $error("ordinary source passed global disable");
	AST_BKP_RAISE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		breakpointMatch |=> bkpFlagReg)
		else $error("breakpoint flag not raised");
	AST_DBG_RAISE: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		dbgHit |=> dbgFlagReg)
		else $error("debug flag not raised");
	AST_NO_SW_SET: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(!i2cmFlagReg && !i2cMasterSet) |=> !i2cmFlagReg)
		else $error("i2c master flag set without hardware event");
	AST_ONE_VECTOR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		takeNow |=> !irqReq)
		else $error("request held after acknowledge");
	AST_TIMER0_CLR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(takeNow && curIdReg == 5'(mic_pkg::SRC_TIMER0)) |=> timer0Clear)
		else $error("timer 0 flag not cleared on entry");
	AST_NO_PREEMPT_HIGH: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		hiActReg |-> arbBus.pend == 15'h0000)
		else $error("high service preempted by ordinary source");
	AST_VECTOR_MAP: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(irqReq && curIdReg == 5'h0E) |-> irqVector == 8'h73)
		else $error("last ordinary vector wrong");
	AST_TIMER1_CLR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(takeNow && curIdReg == 5'(mic_pkg::SRC_TIMER1)) |=> timer1Clear)
		else $error("timer 1 flag not cleared on entry");
	AST_I2CM_SET: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		i2cMasterSet |=> i2cmFlagReg)
		else $error("i2c master flag not raised");
	AST_I2CM_KEEP: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(i2cmFlagReg && !wrFlagExt) |=> i2cmFlagReg)
		else $error("i2c master flag cleared without software");
	AST_PRIO_TOP_ZERO: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		!prMainReg[7])
		else $error("unused priority bit holds a one");
	AST_LOW_NEST: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		loActReg |-> (arbBus.pend & ~arbBus.level) == 15'h0000)
		else $error("low service preempted by low source");
	AST_BKP_VECTOR: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(irqReq && curIdReg == mic_pkg::ID_BREAKPOINT)
		|-> irqVector == mic_pkg::VEC_BREAKPOINT)
		else $error("breakpoint vector wrong");
	AST_DBG_NO_EA: assert property (
		@(posedge core_clk) disable iff (!rst_b)
		(arbBus.dbgReq || arbBus.bkpReq) |-> arbBus.valid)
		else $error("debug or breakpoint request not offered");
endmodule
`default_nettype wire

// ==== testbench/mic_cpu_model.sv ====
// cpu side model: takes each vector after a set delay
// assumes irqReq stands until irqAck; the controller drops it whenever the arbiter has no winner
`timescale 1ns/10ps
`default_nettype none
module mic_cpu_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       irqReq,
	input  wire logic [7:0] irqVector,
	input  wire logic [3:0] ackDelay,
	output logic            irqAck,
	output logic      [7:0] lastVector,
	output logic      [7:0] ackCount
);
	logic [3:0] waitCnt;
	// ack only while the request stands; the vector is taken at that edge
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irqAck     <= 1'b0;
			waitCnt    <= 4'h0;
			lastVector <= 8'h00;
			ackCount   <= 8'h00;
		end else if (irqAck) begin
			irqAck     <= 1'b0;
			waitCnt    <= 4'h0;
			lastVector <= irqVector;
			ackCount   <= ackCount + 8'h01;
		end else if (irqReq) begin
			irqAck     <= (waitCnt >= ackDelay);
			waitCnt    <= waitCnt + 4'h1;
		end else begin
			waitCnt    <= 4'h0;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/mic_ctrl_tb.sv ====
// testbench of the interrupt controller with a cpu model
// assumes register reads answer one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
module mic_ctrl_tb;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [7:0]  regWdata = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [7:0]  regRdata;
	logic [14:0] srcLevel = 15'h0000;
	logic        i2cMasterSet = 1'b0;
	logic        debugPortMode = 1'b0;
	logic        debugReqStb = 1'b0;
	logic [7:0]  debugReqId = 8'h00;
	logic        breakpointMatch = 1'b0;
	logic        irqAck;
	logic        irqReturn = 1'b0;
	logic        irqReq;
	logic [7:0]  irqVector;
	logic        timer0Clear;
	logic        timer1Clear;
	logic [1:0]  inServiceLevel;
	logic [3:0]  ackDelay = 4'h1;
	logic [7:0]  lastVector;
	logic [7:0]  ackCount;
	logic [7:0]  clr0Count = 8'h00;
	logic [7:0]  clr1Count = 8'h00;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;

	mic_ctrl i_mic_ctrl (.core_clk, .rst_b, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .srcLevel, .i2cMasterSet, .debugPortMode,
		.debugReqStb, .debugReqId, .breakpointMatch, .irqAck, .irqReturn,
		.irqReq, .irqVector, .timer0Clear, .timer1Clear, .inServiceLevel);
	mic_cpu_model i_mic_cpu_model (.core_clk, .rst_b, .irqReq, .irqVector,
		.ackDelay, .irqAck, .lastVector, .ackCount);

	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (timer0Clear)
			clr0Count <= clr0Count + 8'h01;
		if (timer1Clear)
			clr1Count <= clr1Count + 8'h01;
		// a hang counts as a mismatch
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 cmp8(regRdata, exp);
	endtask
	task automatic src(input logic [14:0] v);
		@(posedge core_clk);
		srcLevel <= v;
	endtask
	task automatic ret();
		@(posedge core_clk);
		irqReturn <= 1'b1;
		@(posedge core_clk);
		irqReturn <= 1'b0;
	endtask
	task automatic none(input int n);
		repeat (n) @(posedge core_clk);
		#1 cmp8({7'h00, irqReq}, 8'h00);
	endtask
	task automatic dbg(input logic m, input logic [7:0] id, input logic b);
		@(posedge core_clk);
		debugPortMode <= m;
		debugReqId <= id;
		debugReqStb <= 1'b1;
		breakpointMatch <= b;
		@(posedge core_clk);
		debugReqStb <= 1'b0;
		breakpointMatch <= 1'b0;
	endtask
	// waits for the next ack, then checks vector and in-service level
	task automatic take(input logic [7:0] vec, input logic [7:0] lvl);
		logic [7:0] c0;
		int n;
		c0 = ackCount;
		n = 0;
		while (ackCount === c0 && n < 60) begin
			@(posedge core_clk);
			#1 n++;
		end
		cmp8(lastVector, vec);
		repeat (3) @(posedge core_clk);
		#1 cmp8({6'h00, inServiceLevel}, lvl);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(8'hA8, 8'h00);
		rd(8'hB8, 8'h00);
		rd(8'hE8, 8'h00);
		rd(8'hF8, 8'h00);
		rd(8'h91, 8'h00);
		rd(8'h55, 8'h00);
		wr(8'hB8, 8'hFF);
		rd(8'hB8, 8'h7F);
		wr(8'hF8, 8'hA5);
		rd(8'hF8, 8'hA5);
		wr(8'hE8, 8'h5A);
		rd(8'hE8, 8'h5A);
		wr(8'h91, 8'hFF);
		rd(8'h91, 8'h00);
		$display("test registers done");
		wr(8'hB8, 8'h00);
		wr(8'hF8, 8'h00);
		wr(8'hE8, 8'hFF);
		wr(8'hA8, 8'h7F);
		src(15'h0001);
		none(6);
		wr(8'hA8, 8'h80);
		none(6);
		wr(8'hA8, 8'hFF);
		take(8'h03, 8'h01);
		src(15'h0000);
		ret();
		$display("test enables done");
		// every lower source but the i2c master stays pending so the order decides
		for (int i = 0; i < 15; i++) begin
			if (i == 7) begin
				@(posedge core_clk);
				i2cMasterSet <= 1'b1;
				@(posedge core_clk);
				i2cMasterSet <= 1'b0;
			end
			src(15'h7FFF << i);
			take(8'h03 + 8'(8 * i), 8'h01);
			if (i == 8) begin
				rd(8'h91, 8'hEE);
				wr(8'h91, 8'h00);
				rd(8'h91, 8'hEE);
			end
			src(15'h0000);
			if (i == 7) begin
				rd(8'h91, 8'h01);
				wr(8'h91, 8'h00);
				rd(8'h91, 8'h00);
			end
			ret();
		end
		cmp8(clr0Count, 8'h01);
		cmp8(clr1Count, 8'h01);
		$display("test natural order done");
		wr(8'hF8, 8'h80);
		ackDelay <= 4'hF;
		src(15'h4001);
		repeat (10) @(posedge core_clk);
		#1 cmp8({7'h00, irqReq}, 8'h01);
		take(8'h73, 8'h02);
		ackDelay <= 4'h1;
		src(15'h0001);
		none(6);
		ret();
		take(8'h03, 8'h01);
		src(15'h4001);
		take(8'h73, 8'h02);
		src(15'h0000);
		ret();
		ret();
		repeat (3) @(posedge core_clk);
		#1 cmp8({6'h00, inServiceLevel}, 8'h00);
		$display("test levels done");
		wr(8'hA8, 8'h00);
		wr(8'hEF, 8'h5A);
		rd(8'hEF, 8'h5A);
		dbg(1'b1, 8'h33, 1'b0);
		none(6);
		dbg(1'b0, 8'h5A, 1'b0);
		none(6);
		dbg(1'b0, 8'h00, 1'b1);
		take(8'h7B, 8'h03);
		ret();
		dbg(1'b1, 8'h5A, 1'b0);
		take(8'h83, 8'h03);
		ret();
		wr(8'hA8, 8'hFF);
		ackDelay <= 4'h8;
		src(15'h4000);
		dbg(1'b1, 8'h5A, 1'b1);
		take(8'h83, 8'h03);
		ret();
		take(8'h7B, 8'h03);
		ret();
		take(8'h73, 8'h02);
		src(15'h0000);
		ret();
		$display("test debug done");
		close_out();
	end
endmodule
`default_nettype wire
